// ===== pdm_pkg.sv
// Purpose: Shared constants and types of the power-down mode controller
// Assumes: One 125 MHz clock; registers reached over AXI4-Lite
// Notes:   Settle lengths are in oscillator states, one state per clock
`default_nettype none
package pdm_pkg;
	// ==========================================================
	// Register map
	localparam int          ADDR_W         = 4;
	localparam logic [3:0]  REG_SYSCTL     = 4'h0;
	localparam logic [3:0]  REG_STATUS     = 4'h4;
	localparam logic [7:0]  SYSCTL_RESET   = 8'h09;
	localparam int          BIT_SBSEL      = 7;
	localparam int          STS_LSB        = 4;
	localparam int          BIT_RSV        = 3;
	localparam int          BIT_EDGE_SEL   = 2;
	localparam int          BIT_MEM_EN     = 0;
	localparam int          STAT_BUSY      = 8;
	localparam int          STAT_MASK      = 9;
	localparam logic [1:0]  RESP_OKAY      = 2'h0;
	localparam logic [1:0]  RESP_SLVERR    = 2'h2;
	// ==========================================================
	// Settling waits in oscillator states
	localparam int          SETTLE_W       = 18;
	localparam logic [17:0] SETTLE_LEN_0   = 18'h0_2000;
	localparam logic [17:0] SETTLE_LEN_1   = 18'h0_4000;
	localparam logic [17:0] SETTLE_LEN_2   = 18'h0_8000;
	localparam logic [17:0] SETTLE_LEN_3   = 18'h1_0000;
	localparam logic [17:0] SETTLE_LEN_4   = 18'h2_0000;
	// ==========================================================
	// Synchronised pin vector layout
	localparam int          PIN_N          = 11;
	localparam int          PIN_INIT       = 0;
	localparam int          PIN_PWRDN      = 1;
	localparam int          PIN_NMI        = 2;
	localparam int          PIN_IRQ_LO     = 3;
	localparam int          PIN_IRQ_HI     = 6;
	// ==========================================================
	// Power states
	typedef enum logic [6:0] {
		ST_RUN    = 7'h01,
		ST_SLEEP  = 7'h02,
		ST_SWSTBY = 7'h04,
		ST_SETTLE = 7'h08,
		ST_RSTW   = 7'h10,
		ST_HWSTBY = 7'h20,
		ST_HWWAKE = 7'h40
	} pdm_state_t;
endpackage
`default_nettype wire

// ===== pdm_settle_timer.sv
// Purpose: Oscillator settling counter, loaded from the select field
// Assumes: Clear has priority over load
// Notes:   Done pulses exactly len cycles after the load cycle
`default_nettype none
module pdm_settle_timer #(
	parameter logic [17:0] P_LEN_0 = pdm_pkg::SETTLE_LEN_0,
	parameter logic [17:0] P_LEN_1 = pdm_pkg::SETTLE_LEN_1,
	parameter logic [17:0] P_LEN_2 = pdm_pkg::SETTLE_LEN_2,
	parameter logic [17:0] P_LEN_3 = pdm_pkg::SETTLE_LEN_3,
	parameter logic [17:0] P_LEN_4 = pdm_pkg::SETTLE_LEN_4
) (
	input  wire logic       i_clk,
	input  wire logic       i_rst_n,
	input  wire logic       i_load,
	input  wire logic       i_clear,
	input  wire logic [2:0] i_sel,
	output logic            o_busy,
	output logic            o_done
);
	import pdm_pkg::*;

	typedef struct packed {
		logic [SETTLE_W-1:0] cnt;
		logic                busy;
		logic                done;
	} pdm_tmr_t;

	pdm_tmr_t q;
	pdm_tmr_t d;

	// ==========================================================
	// Length lookup
	function automatic logic [SETTLE_W-1:0] sel_len(input logic [2:0] s);
		logic [SETTLE_W-1:0] r;
		r = P_LEN_4;
		if (!s[2]) begin
			case (s[1:0])
				2'h0:    r = P_LEN_0;
				2'h1:    r = P_LEN_1;
				2'h2:    r = P_LEN_2;
				default: r = P_LEN_3;
			endcase
		end
		return r;
	endfunction

	always_comb begin
		d      = q;
		d.done = 1'b0;
		if (i_clear) begin
			d.busy = 1'b0;
			d.cnt  = '0;
		end else if (i_load) begin
			// Load cycle counts as the first state, so the wait is exactly len
			d.cnt  = sel_len(i_sel) - 18'h0_0001;
			d.busy = d.cnt != '0;
			d.done = d.cnt == '0;
		end else if (q.busy) begin
			d.cnt = q.cnt - 18'h0_0001;
			if (q.cnt == 18'h0_0001) begin
				d.busy = 1'b0;
				d.done = 1'b1;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign o_busy = q.busy;
	assign o_done = q.done;

	// ==========================================================
	// Checks
	property p_len_top;
		@(posedge i_clk) disable iff (!i_rst_n)
		i_load && !i_clear && i_sel[2] |=> q.cnt == P_LEN_4 - 18'h0_0001 && o_busy;
	endproperty
	a_len_top: assert property (p_len_top) else $error("top code length wrong");

	property p_len_zero;
		@(posedge i_clk) disable iff (!i_rst_n)
		i_load && !i_clear && i_sel == 3'h0 |=> q.cnt == P_LEN_0 - 18'h0_0001;
	endproperty
	a_len_zero: assert property (p_len_zero) else $error("zero code length wrong");

	property p_done;
		@(posedge i_clk) disable iff (!i_rst_n)
		q.busy && q.cnt == 18'h0_0001 && !i_clear && !i_load |=> o_done && !o_busy;
	endproperty
	a_done: assert property (p_done) else $error("settle end missed");
endmodule
`default_nettype wire

// ===== pdm_ctrl.sv
// Purpose: Power-down mode controller: sleep, software and hardware standby
// Assumes: Pins are asynchronous; CPU strobes are on I_MCLK
// Notes:   Clock enables model gating; this block itself never stops
`default_nettype none
module pdm_ctrl #(
	parameter logic [17:0] P_SETTLE_0 = pdm_pkg::SETTLE_LEN_0,
	parameter logic [17:0] P_SETTLE_1 = pdm_pkg::SETTLE_LEN_1,
	parameter logic [17:0] P_SETTLE_2 = pdm_pkg::SETTLE_LEN_2,
	parameter logic [17:0] P_SETTLE_3 = pdm_pkg::SETTLE_LEN_3,
	parameter logic [17:0] P_SETTLE_4 = pdm_pkg::SETTLE_LEN_4
) (
	input  wire logic                       I_MCLK,
	input  wire logic                       I_RESETN,
	input  wire logic                       I_CHIP_INIT_PIN_N,
	input  wire logic                       I_POWERDOWN_PIN_N,
	input  wire logic                       I_NMI_PIN,
	input  wire logic [2:0]                 I_EXT_INT_LINES_LOW_N,
	input  wire logic [4:0]                 I_EXT_INT_LINES_HIGH_N,
	input  wire logic                       I_SLEEP_EXEC,
	input  wire logic                       I_INT_MASK,
	input  wire logic                       I_PERIPH_INT_REQ,
	input  wire logic                       I_AXI_AWVALID,
	output logic                            O_AXI_AWREADY,
	input  wire logic [pdm_pkg::ADDR_W-1:0] I_AXI_AWADDR,
	input  wire logic                       I_AXI_WVALID,
	output logic                            O_AXI_WREADY,
	input  wire logic [31:0]                I_AXI_WDATA,
	input  wire logic [3:0]                 I_AXI_WSTRB,
	output logic                            O_AXI_BVALID,
	input  wire logic                       I_AXI_BREADY,
	output logic [1:0]                      O_AXI_BRESP,
	input  wire logic                       I_AXI_ARVALID,
	output logic                            O_AXI_ARREADY,
	input  wire logic [pdm_pkg::ADDR_W-1:0] I_AXI_ARADDR,
	output logic                            O_AXI_RVALID,
	input  wire logic                       I_AXI_RREADY,
	output logic [31:0]                     O_AXI_RDATA,
	output logic [1:0]                      O_AXI_RRESP,
	output logic                            O_CPU_HALT,
	output logic                            O_CPU_RESET,
	output logic                            O_CPU_CLK_EN,
	output logic                            O_PERIPH_CLK_EN,
	output logic                            O_PERIPH_RESET,
	output logic                            O_OSC_RUN,
	output logic                            O_IO_HOLD,
	output logic                            O_IO_HIZ,
	output logic                            O_INT_WAKE,
	output logic                            O_RESET_SEQ,
	output logic                            O_NMI_EVENT,
	output logic                            O_ONCHIP_MEMORY_ENABLE,
	output logic [6:0]                      O_POWER_STATE
);
	import pdm_pkg::*;

	typedef struct packed {
		pdm_state_t        st;
		logic [PIN_N-1:0]  pin_s1;
		logic [PIN_N-1:0]  pin_s2;
		logic [PIN_N-1:0]  pin_p;
		logic              sb_sel;
		logic [2:0]        sts;
		logic              edge_sel;
		logic              mem_en;
		logic              mask;
		logic              int_wake;
		logic              rst_seq;
		logic              nmi_evt;
		logic              aw_ok;
		logic [ADDR_W-1:0] awaddr;
		logic              w_ok;
		logic [31:0]       wdata;
		logic              wstrb0;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              rvalid;
		logic [31:0]       rdata;
		logic [1:0]        rresp;
	} pdm_regs_t;

	pdm_regs_t q;
	pdm_regs_t d;
	logic      rst_s1_q;
	logic      rst_n;
	logic      tmr_load;
	logic      tmr_clear;
	logic      tmr_busy;
	logic      tmr_done;
	logic      init_lo;
	logic      init_rise;
	logic      pwrdn_lo;
	logic      nmi_edge;
	logic      irq_lo_req;
	logic      irq_hi_req;
	logic      sleep_wake;
	logic      standby_wake;

	// ==========================================================
	// Reset release
	always_ff @(posedge I_MCLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			rst_s1_q <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n    <= rst_s1_q;
		end
	end

	// ==========================================================
	// Settle counter
	pdm_settle_timer #(
		.P_LEN_0 (P_SETTLE_0),
		.P_LEN_1 (P_SETTLE_1),
		.P_LEN_2 (P_SETTLE_2),
		.P_LEN_3 (P_SETTLE_3),
		.P_LEN_4 (P_SETTLE_4)
	) u_timer (
		.i_clk   (I_MCLK),
		.i_rst_n (rst_n),
		.i_load  (tmr_load),
		.i_clear (tmr_clear),
		.i_sel   (q.sts),
		.o_busy  (tmr_busy),
		.o_done  (tmr_done)
	);

	// ==========================================================
	// Pin events from the second synchroniser stage; edges also compare it with its delayed copy pin_p
	assign init_lo   = !q.pin_s2[PIN_INIT];
	assign init_rise = q.pin_s2[PIN_INIT] && !q.pin_p[PIN_INIT];
	assign pwrdn_lo  = !q.pin_s2[PIN_PWRDN];
	assign nmi_edge = q.edge_sel ? (q.pin_s2[PIN_NMI] && !q.pin_p[PIN_NMI])
	                             : (!q.pin_s2[PIN_NMI] && q.pin_p[PIN_NMI]);
	assign irq_lo_req = !(&q.pin_s2[PIN_IRQ_LO +: 3]);
	assign irq_hi_req = !(&q.pin_s2[PIN_IRQ_HI +: 5]);
	// Peripheral request arrives already gated by its own enable bit
	assign sleep_wake = nmi_edge ||
	                    (!q.mask && (irq_lo_req || irq_hi_req || I_PERIPH_INT_REQ));
	// High lines cannot restart the oscillator, hence they are left out of the standby wake
	assign standby_wake = nmi_edge || irq_lo_req;
	assign tmr_load   = q.st == ST_SWSTBY && !pwrdn_lo && !init_lo && standby_wake;
	assign tmr_clear  = q.st != ST_SETTLE && !tmr_load;

	// ==========================================================
	// Next state
	always_comb begin
		d          = q;
		d.pin_s1   = {I_EXT_INT_LINES_HIGH_N, I_EXT_INT_LINES_LOW_N, I_NMI_PIN,
		              I_POWERDOWN_PIN_N, I_CHIP_INIT_PIN_N};
		d.pin_s2   = q.pin_s1;
		d.pin_p    = q.pin_s2;
		d.int_wake = 1'b0;
		d.rst_seq  = 1'b0;
		d.nmi_evt  = nmi_edge;

		// Register writes, either channel may come first
		if (I_AXI_AWVALID && O_AXI_AWREADY) begin
			d.aw_ok  = 1'b1;
			d.awaddr = I_AXI_AWADDR;
		end
		if (I_AXI_WVALID && O_AXI_WREADY) begin
			d.w_ok   = 1'b1;
			d.wdata  = I_AXI_WDATA;
			d.wstrb0 = I_AXI_WSTRB[0];
		end
		if (q.bvalid && I_AXI_BREADY) begin
			d.bvalid = 1'b0;
		end
		if (q.aw_ok && q.w_ok && !q.bvalid) begin
			d.aw_ok  = 1'b0;
			d.w_ok   = 1'b0;
			d.bvalid = 1'b1;
			d.bresp  = RESP_OKAY;
			if (q.awaddr == REG_SYSCTL) begin
				if (q.wstrb0) begin
					d.sb_sel   = q.wdata[BIT_SBSEL];
					d.sts      = q.wdata[STS_LSB +: 3];
					d.edge_sel = q.wdata[BIT_EDGE_SEL];
					d.mem_en   = q.wdata[BIT_MEM_EN];
				end
			end else if (q.awaddr != REG_STATUS) begin
				d.bresp = RESP_SLVERR;
			end
		end

		// Register reads
		if (q.rvalid && I_AXI_RREADY) begin
			d.rvalid = 1'b0;
		end
		if (I_AXI_ARVALID && O_AXI_ARREADY) begin
			d.rvalid = 1'b1;
			d.rresp  = RESP_OKAY;
			d.rdata  = '0;
			if (I_AXI_ARADDR == REG_SYSCTL) begin
				d.rdata[BIT_SBSEL]      = q.sb_sel;
				d.rdata[STS_LSB +: 3]   = q.sts;
				d.rdata[BIT_RSV]        = SYSCTL_RESET[BIT_RSV];
				d.rdata[BIT_EDGE_SEL]   = q.edge_sel;
				d.rdata[BIT_MEM_EN]     = q.mem_en;
			end else if (I_AXI_ARADDR == REG_STATUS) begin
				d.rdata[6:0]            = q.st;
				d.rdata[STAT_BUSY]      = tmr_busy;
				d.rdata[STAT_MASK]      = q.mask;
			end else begin
				d.rresp = RESP_SLVERR;
			end
		end

		// Power sequencing; standby pin beats reset pin beats the rest
		if (pwrdn_lo) begin
			d.st = ST_HWSTBY;
		end else begin
			case (q.st)
				ST_RUN: begin
					if (init_lo) begin
						d.st = ST_RSTW;
					end else if (I_SLEEP_EXEC) begin
						d.mask = I_INT_MASK;
						d.st   = q.sb_sel ? ST_SWSTBY : ST_SLEEP;
					end
				end
				ST_SLEEP: begin
					if (init_lo) begin
						d.st = ST_RSTW;
					end else if (sleep_wake) begin
						d.st       = ST_RUN;
						d.int_wake = 1'b1;
					end
				end
				ST_SWSTBY: begin
					if (init_lo) begin
						d.st = ST_RSTW;
					end else if (standby_wake) begin
						d.st = ST_SETTLE;
					end
				end
				ST_SETTLE: begin
					if (init_lo) begin
						d.st = ST_RSTW;
					end else if (tmr_done) begin
						d.st       = ST_RUN;
						d.int_wake = 1'b1;
					end
				end
				ST_RSTW: begin
					if (!init_lo) begin
						d.st      = ST_RUN;
						d.rst_seq = 1'b1;
						d.sb_sel  = 1'b0;
					end
				end
				ST_HWSTBY: begin
					d.st = ST_HWWAKE;
				end
				ST_HWWAKE: begin
					// A reset pin already high here never rises, so the chip waits
					if (init_rise) begin
						d.st      = ST_RUN;
						d.rst_seq = 1'b1;
						d.sb_sel  = 1'b0;
					end
				end
				default: begin
					d.st = ST_RUN;
				end
			endcase
		end
	end

	always_ff @(posedge I_MCLK or negedge rst_n) begin
		if (!rst_n) begin
			q        <= '0;
			q.st     <= ST_RUN;
			q.pin_s1 <= '1;
			q.pin_s2 <= '1;
			q.pin_p  <= '1;
			q.sb_sel   <= SYSCTL_RESET[BIT_SBSEL];
			q.sts      <= SYSCTL_RESET[STS_LSB +: 3];
			q.edge_sel <= SYSCTL_RESET[BIT_EDGE_SEL];
			q.mem_en   <= SYSCTL_RESET[BIT_MEM_EN];
		end else begin
			q <= d;
		end
	end

	// ==========================================================
	// Outputs, decoded from the registered state
	assign O_AXI_AWREADY = !q.aw_ok && !q.bvalid;
	assign O_AXI_WREADY  = !q.w_ok && !q.bvalid;
	assign O_AXI_BVALID  = q.bvalid;
	assign O_AXI_BRESP   = q.bresp;
	assign O_AXI_ARREADY = !q.rvalid;
	assign O_AXI_RVALID  = q.rvalid;
	assign O_AXI_RDATA   = q.rdata;
	assign O_AXI_RRESP   = q.rresp;

	assign O_CPU_HALT      = q.st != ST_RUN;
	assign O_CPU_RESET     = q.st == ST_RSTW || q.st == ST_HWSTBY || q.st == ST_HWWAKE;
	assign O_CPU_CLK_EN    = !(q.st == ST_SWSTBY || q.st == ST_SETTLE
	                           || q.st == ST_HWSTBY);
	assign O_PERIPH_CLK_EN = O_CPU_CLK_EN;
	assign O_PERIPH_RESET  = q.st == ST_SWSTBY || q.st == ST_SETTLE || O_CPU_RESET;
	assign O_OSC_RUN       = !(q.st == ST_SWSTBY || q.st == ST_HWSTBY);
	assign O_IO_HOLD       = q.st == ST_SWSTBY || q.st == ST_SETTLE;
	assign O_IO_HIZ        = q.st == ST_HWSTBY || q.st == ST_HWWAKE;
	assign O_INT_WAKE      = q.int_wake;
	assign O_RESET_SEQ     = q.rst_seq;
	assign O_NMI_EVENT     = q.nmi_evt;
	assign O_ONCHIP_MEMORY_ENABLE = q.mem_en;
	assign O_POWER_STATE   = q.st;

	// ==========================================================
	// Checks
	property p_hw_entry;
		@(posedge I_MCLK) disable iff (!rst_n)
		pwrdn_lo |=> q.st == ST_HWSTBY && O_IO_HIZ && O_CPU_HALT;
	endproperty
	a_hw_entry: assert property (p_hw_entry) else $error("standby pin ignored");

	property p_sleep_entry;
		@(posedge I_MCLK) disable iff (!rst_n)
		q.st == ST_RUN && I_SLEEP_EXEC && !pwrdn_lo && !init_lo
		|=> (q.st == ($past(q.sb_sel) ? ST_SWSTBY : ST_SLEEP)) && O_CPU_HALT;
	endproperty
	a_sleep_entry: assert property (p_sleep_entry) else $error("sleep entry wrong");

	property p_sleep_periph;
		@(posedge I_MCLK) disable iff (!rst_n)
		q.st == ST_SLEEP |-> O_PERIPH_CLK_EN && !O_PERIPH_RESET && O_CPU_HALT;
	endproperty
	a_sleep_periph: assert property (p_sleep_periph) else $error("sleep stops peripherals");

	property p_masked_sleep;
		@(posedge I_MCLK) disable iff (!rst_n)
		q.st == ST_SLEEP && q.mask && !nmi_edge && !pwrdn_lo && !init_lo |=> q.st == ST_SLEEP;
	endproperty
	a_masked_sleep: assert property (p_masked_sleep) else $error("masked wake");

	property p_sleep_wake;
		@(posedge I_MCLK) disable iff (!rst_n)
		q.st == ST_SLEEP && sleep_wake && !pwrdn_lo && !init_lo |=> O_INT_WAKE && !O_CPU_HALT;
	endproperty
	a_sleep_wake: assert property (p_sleep_wake) else $error("interrupt did not wake");

	property p_sleep_reset;
		@(posedge I_MCLK) disable iff (!rst_n)
		q.st == ST_SLEEP && init_lo && !pwrdn_lo |=> O_CPU_RESET;
	endproperty
	a_sleep_reset: assert property (p_sleep_reset) else $error("reset pin ignored");

	property p_settle_gate;
		@(posedge I_MCLK) disable iff (!rst_n)
		tmr_load |=> (!O_CPU_CLK_EN && O_OSC_RUN && O_IO_HOLD) [*2];
	endproperty
	a_settle_gate: assert property (p_settle_gate) else $error("clock leaked in settle");

	property p_settle_exit;
		@(posedge I_MCLK) disable iff (!rst_n)
		q.st == ST_SETTLE && tmr_done && !pwrdn_lo && !init_lo
		|=> O_INT_WAKE && q.sb_sel == $past(q.sb_sel) && O_CPU_CLK_EN;
	endproperty
	a_settle_exit: assert property (p_settle_exit) else $error("settle exit wrong");

	property p_reset_release;
		@(posedge I_MCLK) disable iff (!rst_n)
		q.st == ST_RSTW && !init_lo && !pwrdn_lo |=> O_RESET_SEQ && !q.sb_sel && !O_CPU_RESET;
	endproperty
	a_reset_release: assert property (p_reset_release) else $error("reset release wrong");

	property p_hw_exit;
		@(posedge I_MCLK) disable iff (!rst_n)
		q.st == ST_HWWAKE && !pwrdn_lo && !init_rise |=> O_CPU_RESET && O_OSC_RUN;
	endproperty
	a_hw_exit: assert property (p_hw_exit) else $error("left standby early");

	property p_nmi_edge;
		@(posedge I_MCLK) disable iff (!rst_n)
		q.pin_s2[PIN_NMI] && !q.pin_p[PIN_NMI] |=> O_NMI_EVENT == $past(q.edge_sel);
	endproperty
	a_nmi_edge: assert property (p_nmi_edge) else $error("NMI edge select wrong");
endmodule
`default_nettype wire

// ===== pdm_pins_model.sv
// Purpose: Board logic driving the reset, standby and interrupt pins
// Assumes: Pins change just after a rising clock edge
// Notes:   Settle spans are in clocks, chosen by the caller
`default_nettype none
module pdm_pins_model (
	input  wire logic       i_clk,
	output logic            o_init_n,
	output logic            o_pwrdn_n,
	output logic            o_nmi,
	output logic [2:0]      o_lo_n,
	output logic [4:0]      o_hi_n
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// Pin sequences
	initial begin
		o_init_n = 1'b1;
		o_pwrdn_n = 1'b1;
		o_nmi = 1'b1;
		o_lo_n = 3'h7;
		o_hi_n = 5'h1f;
	end
	task automatic init_low();
		@(posedge i_clk) o_init_n <= 1'b0;
	endtask
	// Long settle models a slow oscillator
	task automatic init_release(input int settle);
		repeat (settle) @(posedge i_clk);
		o_init_n <= 1'b1;
	endtask
	task automatic hw_enter();
		init_low();
		repeat (2) @(posedge i_clk);
		o_pwrdn_n <= 1'b0;
	endtask
	task automatic pwrdn_high();
		@(posedge i_clk) o_pwrdn_n <= 1'b1;
	endtask
	// Opposite level first, so a wrong edge choice wakes early if the pin already sits at the requested level
	task automatic nmi_edge(input logic rise);
		@(posedge i_clk) o_nmi <= ~rise;
		repeat (4) @(posedge i_clk);
		o_nmi <= rise;
	endtask
	task automatic lines(input logic [2:0] lo, input logic [4:0] hi);
		@(posedge i_clk) o_lo_n <= lo;
		o_hi_n <= hi;
	endtask
endmodule
`default_nettype wire

// ===== power_down_mode_control_tb.sv
// Purpose: Self-checking bench of the power-down mode controller
// Assumes: Short settle lengths set through the top parameters
// Notes:   Pins come from the board model; registers over AXI4-Lite
`default_nettype none
module power_down_mode_control_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import pdm_pkg::*;
	// External clock assumed, so any code is legal and the shortest comes first
	localparam logic [17:0] SL [5] = '{18'h0_0004, 18'h0_0005, 18'h0_0006, 18'h0_0007, 18'h0_0008};
	logic I_MCLK, I_RESETN, I_CHIP_INIT_PIN_N, I_POWERDOWN_PIN_N, I_NMI_PIN, I_SLEEP_EXEC;
	logic I_INT_MASK, I_PERIPH_INT_REQ, I_AXI_AWVALID, I_AXI_WVALID, I_AXI_BREADY;
	logic I_AXI_ARVALID, I_AXI_RREADY, O_AXI_AWREADY, O_AXI_WREADY, O_AXI_BVALID, O_AXI_ARREADY;
	logic O_AXI_RVALID, O_CPU_HALT, O_CPU_RESET, O_CPU_CLK_EN, O_PERIPH_CLK_EN, O_PERIPH_RESET;
	logic O_OSC_RUN, O_IO_HOLD, O_IO_HIZ, O_INT_WAKE, O_RESET_SEQ, O_NMI_EVENT;
	logic O_ONCHIP_MEMORY_ENABLE;
	logic [2:0]        I_EXT_INT_LINES_LOW_N;
	logic [4:0]        I_EXT_INT_LINES_HIGH_N;
	logic [ADDR_W-1:0] I_AXI_AWADDR, I_AXI_ARADDR;
	logic [3:0]        I_AXI_WSTRB;
	logic [31:0]       I_AXI_WDATA, O_AXI_RDATA, d;
	logic [1:0]        O_AXI_BRESP, O_AXI_RRESP, r;
	logic [6:0]        O_POWER_STATE;
	logic              e;
	int                errors, check_count, n, src;
	pdm_ctrl #(.P_SETTLE_0(SL[0]), .P_SETTLE_1(SL[1]), .P_SETTLE_2(SL[2]),
		.P_SETTLE_3(SL[3]), .P_SETTLE_4(SL[4])) dut_u (.*);
	pdm_pins_model pins_u (.i_clk(I_MCLK), .o_init_n(I_CHIP_INIT_PIN_N),
		.o_pwrdn_n(I_POWERDOWN_PIN_N), .o_nmi(I_NMI_PIN),
		.o_lo_n(I_EXT_INT_LINES_LOW_N), .o_hi_n(I_EXT_INT_LINES_HIGH_N));
	// ==========================================================
	// Helpers
	function automatic logic [31:0] exp_len(input logic [2:0] c);
		return c[2] ? SL[4] : SL[c[1:0]];
	endfunction
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic step(input int k);
		repeat (k) @(posedge I_MCLK);
		#1;
	endtask
	task automatic wait_st(input logic [6:0] s, input int mx);
		n = 0;
		do begin
			step(1);
			n++;
		end while (O_POWER_STATE !== s && n < mx);
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		bit ad, wd;
		ad = 0;
		wd = 0;
		@(posedge I_MCLK);
		I_AXI_AWVALID <= 1'b1;
		I_AXI_WVALID <= 1'b1;
		I_AXI_BREADY <= 1'b1;
		I_AXI_AWADDR <= a;
		I_AXI_WDATA <= v;
		while (!(ad && wd)) begin
			@(posedge I_MCLK);
			if (O_AXI_AWREADY) I_AXI_AWVALID <= 1'b0;
			if (O_AXI_WREADY) I_AXI_WVALID <= 1'b0;
			ad |= O_AXI_AWREADY;
			wd |= O_AXI_WREADY;
		end
		do @(posedge I_MCLK); while (!O_AXI_BVALID);
		chk("bresp", RESP_OKAY, O_AXI_BRESP);
		I_AXI_BREADY <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge I_MCLK);
		I_AXI_ARVALID <= 1'b1;
		I_AXI_ARADDR <= a;
		I_AXI_RREADY <= 1'b1;
		do @(posedge I_MCLK); while (!O_AXI_ARREADY);
		I_AXI_ARVALID <= 1'b0;
		do @(posedge I_MCLK); while (!O_AXI_RVALID);
		d = O_AXI_RDATA;
		r = O_AXI_RRESP;
		I_AXI_RREADY <= 1'b0;
	endtask
	task automatic sleep(input logic m);
		@(posedge I_MCLK);
		I_INT_MASK <= m;
		I_SLEEP_EXEC <= 1'b1;
		@(posedge I_MCLK);
		I_SLEEP_EXEC <= 1'b0;
		#1;
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// ==========================================================
	// Clock, watchdog and tests
	initial begin
		I_MCLK = 1'b0;
		forever #4 I_MCLK = ~I_MCLK;
	end
	initial begin
		repeat (20000) @(posedge I_MCLK);
		errors++;
		$display("BAD watchdog expected done seen hang");
		complete_run();
	end
	initial begin
		{I_RESETN, I_SLEEP_EXEC, I_INT_MASK, I_PERIPH_INT_REQ} = 4'h0;
		{I_AXI_AWVALID, I_AXI_WVALID, I_AXI_BREADY, I_AXI_ARVALID, I_AXI_RREADY} = 5'h00;
		{I_AXI_AWADDR, I_AXI_ARADDR, I_AXI_WDATA, I_AXI_WSTRB} = {8'h00, 32'h0000_0000, 4'hf};
		n = $urandom(32'h7a0a);
		repeat (5) @(posedge I_MCLK);
		I_RESETN <= 1'b1;
		step(3);
		chk("state", ST_RUN, O_POWER_STATE);
		rd(REG_SYSCTL);
		chk("sysctl", SYSCTL_RESET, d);
		rd(4'h8);
		chk("rresp", RESP_SLVERR, r);
		$display("test reset done");
		sleep(1'b0);
		chk("state", ST_SLEEP, O_POWER_STATE);
		chk("periph clk", 1, O_PERIPH_CLK_EN);
		chk("halt", 1, O_CPU_HALT);
		I_PERIPH_INT_REQ <= 1'b1;
		wait_st(ST_RUN, 20);
		chk("wake", 1, O_INT_WAKE);
		I_PERIPH_INT_REQ <= 1'b0;
		sleep(1'b1);
		I_PERIPH_INT_REQ <= 1'b1;
		pins_u.lines(3'h6, 5'h1f);
		step(10);
		chk("state", ST_SLEEP, O_POWER_STATE);
		I_PERIPH_INT_REQ <= 1'b0;
		pins_u.lines(3'h7, 5'h1f);
		pins_u.nmi_edge(1'b0);
		wait_st(ST_RUN, 20);
		chk("wake", 1, O_INT_WAKE);
		sleep(1'b0);
		pins_u.init_low();
		wait_st(ST_RSTW, 20);
		chk("state", ST_RSTW, O_POWER_STATE);
		pins_u.init_release(4);
		wait_st(ST_RUN, 20);
		chk("seq", 1, O_RESET_SEQ);
		$display("test sleep done");
		for (int c = 0; c < 8; c++) begin
			e = 1'($urandom_range(1, 0));
			src = $urandom_range(3, 0);
			wr(REG_SYSCTL, 32'h0000_0089 | (c << 4) | (e << 2));
			sleep(1'b0);
			chk("state", ST_SWSTBY, O_POWER_STATE);
			chk("clk", 0, {O_CPU_CLK_EN, O_PERIPH_CLK_EN, O_OSC_RUN});
			chk("hold", 1, O_IO_HOLD);
			if (c == 0) begin
				pins_u.lines(3'h7, 5'h00);
				step(10);
				chk("state", ST_SWSTBY, O_POWER_STATE);
				pins_u.lines(3'h7, 5'h1f);
			end
			if (src == 3) begin
				pins_u.nmi_edge(e);
				#1;
				chk("edge", ST_SWSTBY, O_POWER_STATE);
			end else
				pins_u.lines(~(3'h1 << src), 5'h1f);
			wait_st(ST_SETTLE, 20);
			chk("nmi event", src == 3, O_NMI_EVENT);
			chk("settle clk", 0, O_CPU_CLK_EN);
			wait_st(ST_RUN, 300);
			chk("settle len", exp_len(3'(c)), n);
			chk("wake", 1, O_INT_WAKE);
			pins_u.lines(3'h7, 5'h1f);
			rd(REG_SYSCTL);
			chk("select", 1, d[BIT_SBSEL]);
		end
		$display("test software standby done");
		sleep(1'b0);
		pins_u.init_low();
		wait_st(ST_RSTW, 20);
		chk("clk", 1, O_CPU_CLK_EN);
		pins_u.init_release(6);
		wait_st(ST_RUN, 20);
		rd(REG_SYSCTL);
		chk("select", 0, d[BIT_SBSEL]);
		$display("test standby reset done");
		wr(REG_SYSCTL, 32'h0000_0008);
		chk("mem", 0, O_ONCHIP_MEMORY_ENABLE);
		sleep(1'b0);
		pins_u.hw_enter();
		wait_st(ST_HWSTBY, 20);
		chk("state", ST_HWSTBY, O_POWER_STATE);
		chk("hiz", 7, {O_IO_HIZ, O_CPU_RESET, O_PERIPH_RESET});
		pins_u.pwrdn_high();
		wait_st(ST_HWWAKE, 20);
		chk("osc", 1, O_OSC_RUN);
		pins_u.init_release(5);
		wait_st(ST_RUN, 20);
		chk("seq", 1, O_RESET_SEQ);
		$display("test hardware standby done");
		complete_run();
	end
endmodule
`default_nettype wire
